// ===== gp_ext_pins.sv
`timescale 1ns/1ps
`include "gp_params.svh"

// ****************************************************************
// Board side of the pins
// ****************************************************************
module gp_ext_pins (
    input  wire logic [`GP_NPIN-1:0] ext_lvl,
    input  wire logic [`GP_NPIN-1:0] pin_out,
    input  wire logic [`GP_NPIN-1:0] pin_oe,
    output logic [`GP_NPIN-1:0]      pin_in
);
    // Driven pins read back their own level, others follow the board
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // gp_ext_pins

// ===== gp_params.svh
`ifndef GP_PARAMS_SVH
`define GP_PARAMS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define GP_NPORT      2
`define GP_PORT_W     32
`define GP_NPIN       64
`define GP_IDX_W      6
`define GP_NPINT      8
`define GP_PINT_W     3
`define GP_NGRP       2
`define GP_MODE_W     3

// ****************************************************************
// Reset values and synchroniser stage count
// ****************************************************************
`define GP_DIR_RST    64'h0000_0000_0000_0000
`define GP_OUT_RST    64'h0000_0000_0000_0000
`define GP_GENA_RST   64'h0000_0000_0000_0000
`define GP_GPOL_RST   64'h0000_0000_0000_0000
`define GP_SRC_RST    6'h00
`define GP_MODE_RST   3'h0
`define GP_SYNC_STG   2

`endif

// ===== gp_pint.sv
`timescale 1ns/1ps
`include "gp_params.svh"

module gp_pint (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  lvl,
    input  wire logic [`GP_MODE_W-1:0] mode,
    input  wire logic                  clr,
    output logic                       req_r
);

    gp_pkg::gp_pmode_e mode_e;
    logic              prev_r;
    logic              flag_r;
    logic              rise;
    logic              fall;
    logic              edge_hit;
    logic              req_nxt;

    assign mode_e = gp_pkg::gp_pmode_e'(mode);
    assign rise   = lvl & ~prev_r;
    assign fall   = ~lvl & prev_r;

    always_comb begin
        edge_hit = 1'b0;
        req_nxt  = flag_r;
        unique case (mode_e)
            gp_pkg::GP_PM_OFF:  req_nxt = 1'b0;
            gp_pkg::GP_PM_HIGH: req_nxt = lvl;
            gp_pkg::GP_PM_LOW:  req_nxt = ~lvl;
            gp_pkg::GP_PM_RISE: edge_hit = rise;
            gp_pkg::GP_PM_FALL: edge_hit = fall;
            gp_pkg::GP_PM_BOTH: edge_hit = rise | fall;
            default:            req_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= lvl;
        end
    end

    // Sticky edge flag, a new edge wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (edge_hit) begin
            flag_r <= 1'b1;
        end else if (clr || mode_e == gp_pkg::GP_PM_OFF) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_r <= 1'b0;
        end else begin
            req_r <= req_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking

    sequence rise_seen_s;
        mode_e == gp_pkg::GP_PM_RISE && rise;
    endsequence

    rise_flags_a: assert property (disable iff (!rst_n)
        rise_seen_s |=> flag_r ##1 req_r)
        else $error("rising edge did not raise request");

    level_high_a: assert property (disable iff (!rst_n)
        (mode_e == gp_pkg::GP_PM_HIGH) |=> req_r == $past(lvl))
        else $error("high level request wrong");

    flag_hold_a: assert property (disable iff (!rst_n)
        flag_r && !clr && mode_e != gp_pkg::GP_PM_OFF |=> flag_r)
        else $error("edge flag lost without clear");

endmodule // gp_pint

// ===== gp_pkg.sv
package gp_pkg;

    // Pin interrupt trigger modes
    typedef enum logic [2:0] {
        GP_PM_OFF,
        GP_PM_HIGH,
        GP_PM_LOW,
        GP_PM_RISE,
        GP_PM_FALL,
        GP_PM_BOTH
    } gp_pmode_e;

endpackage

// ===== gp_port.sv
`timescale 1ns/1ps
`include "gp_params.svh"

module gp_port (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    input  wire logic [`GP_NPIN-1:0]      pin_in,
    output logic [`GP_NPIN-1:0]           pin_out_r,
    output logic [`GP_NPIN-1:0]           pin_oe_r,
    input  wire logic                     dir_wr,
    input  wire logic                     dir_sel,
    input  wire logic [`GP_PORT_W-1:0]    dir_wdata,
    input  wire logic                     port_wr,
    input  wire logic                     port_sel,
    input  wire logic [`GP_PORT_W-1:0]    port_wdata,
    input  wire logic                     set_wr,
    input  wire logic                     clr_wr,
    input  wire logic                     setclr_sel,
    input  wire logic [`GP_PORT_W-1:0]    setclr_mask,
    input  wire logic                     pin_wr,
    input  wire logic [`GP_IDX_W-1:0]     pin_idx,
    input  wire logic                     pin_wdata,
    input  wire logic [`GP_IDX_W-1:0]     pin_rd_idx,
    output logic                          pin_rd_val_r,
    input  wire logic                     port_rd_sel,
    output logic [`GP_PORT_W-1:0]         port_rd_val_r,
    input  wire logic                     pint_wr,
    input  wire logic [`GP_PINT_W-1:0]    pint_ch,
    input  wire logic [`GP_IDX_W-1:0]     pint_src,
    input  wire logic [`GP_MODE_W-1:0]    pint_mode,
    input  wire logic [`GP_NPINT-1:0]     pint_clr,
    output logic [`GP_NPINT-1:0]          pint_req_r,
    input  wire logic                     grp_wr,
    input  wire logic                     grp_id,
    input  wire logic                     grp_port,
    input  wire logic [`GP_PORT_W-1:0]    grp_ena,
    input  wire logic [`GP_PORT_W-1:0]    grp_pol,
    input  wire logic                     grp_and,
    output logic [`GP_NGRP-1:0]           grp_irq_r
);

    // ****************************************************************
    // Reset release and input synchroniser
    // ****************************************************************
    logic                      rst_meta_r;
    logic                      rst_n;
    logic [`GP_NPIN-1:0]       sync1_r;
    logic [`GP_NPIN-1:0]       lvl_r;
    logic [`GP_NPIN-1:0]       out_nxt;
    logic [`GP_IDX_W-1:0]      src_r  [`GP_NPINT];
    logic [`GP_MODE_W-1:0]     mode_r [`GP_NPINT];
    logic [`GP_NPIN-1:0]       gena_r [`GP_NGRP];
    logic [`GP_NPIN-1:0]       gpol_r [`GP_NGRP];
    logic [`GP_NGRP-1:0]       gand_r;
    logic [`GP_NGRP-1:0]       grp_nxt;

    function automatic logic [`GP_NPIN-1:0] place(
        input logic                  sel,
        input logic [`GP_PORT_W-1:0] d
    );
        place = sel ? {d, 32'h0000_0000} : {32'h0000_0000, d};
    endfunction

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            lvl_r   <= '0;
        end else begin
            sync1_r <= pin_in;
            lvl_r   <= sync1_r;
        end
    end

    // ****************************************************************
    // Direction and output value
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_oe_r <= `GP_DIR_RST;
        end else if (dir_wr) begin
            pin_oe_r <= (pin_oe_r & ~place(dir_sel, '1))
                        | place(dir_sel, dir_wdata);
        end
    end

    always_comb begin
        out_nxt = pin_out_r;
        if (port_wr) begin
            out_nxt = (out_nxt & ~place(port_sel, '1))
                      | place(port_sel, port_wdata);
        end
        if (set_wr) begin
            out_nxt = out_nxt | place(setclr_sel, setclr_mask);
        end
        if (clr_wr) begin
            out_nxt = out_nxt & ~place(setclr_sel, setclr_mask);
        end
        if (pin_wr) begin
            out_nxt[pin_idx] = pin_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_r <= `GP_OUT_RST;
        end else begin
            pin_out_r <= out_nxt;
        end
    end

    // ****************************************************************
    // Reads
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_rd_val_r  <= 1'b0;
            port_rd_val_r <= '0;
        end else begin
            pin_rd_val_r  <= lvl_r[pin_rd_idx];
            port_rd_val_r <= port_rd_sel ? lvl_r[63:32] : lvl_r[31:0];
        end
    end

    // ****************************************************************
    // Pin interrupt channels
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `GP_NPINT; gi++) begin : g_pint
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    src_r[gi]  <= `GP_SRC_RST;
                    mode_r[gi] <= `GP_MODE_RST;
                end else if (pint_wr && pint_ch == gi) begin
                    src_r[gi]  <= pint_src;
                    mode_r[gi] <= pint_mode;
                end
            end

            gp_pint u_pint (
                .clk   (ref_clk),
                .rst_n (rst_n),
                .lvl   (lvl_r[src_r[gi]]),
                .mode  (mode_r[gi]),
                .clr   (pint_clr[gi]),
                .req_r (pint_req_r[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Group interrupts
    // ****************************************************************
    generate
        for (gi = 0; gi < `GP_NGRP; gi++) begin : g_grp
            logic [`GP_NPIN-1:0] hit;

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    gena_r[gi] <= `GP_GENA_RST;
                    gpol_r[gi] <= `GP_GPOL_RST;
                    gand_r[gi] <= 1'b0;
                end else if (grp_wr && grp_id == gi) begin
                    gena_r[gi] <= (gena_r[gi] & ~place(grp_port, '1))
                                  | place(grp_port, grp_ena);
                    gpol_r[gi] <= (gpol_r[gi] & ~place(grp_port, '1))
                                  | place(grp_port, grp_pol);
                    gand_r[gi] <= grp_and;
                end
            end

            // A pin hits when enabled and at its chosen level
            assign hit = gena_r[gi] & ~(lvl_r ^ gpol_r[gi]);
            assign grp_nxt[gi] = gand_r[gi]
                ? (|gena_r[gi]) && ((hit | ~gena_r[gi]) == '1)
                : |hit;
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            grp_irq_r <= '0;
        end else begin
            grp_irq_r <= grp_nxt;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking

    reset_state_a: assert property (
        !rst_n |-> pin_oe_r == '0 && grp_irq_r == '0 && pint_req_r == '0)
        else $error("reset state not all inputs and quiet");

    dir_write_a: assert property (disable iff (!rst_n)
        dir_wr |=> (pin_oe_r & place($past(dir_sel), '1))
                   == place($past(dir_sel), $past(dir_wdata)))
        else $error("direction write not applied");

    port_write_a: assert property (disable iff (!rst_n)
        port_wr && !set_wr && !clr_wr && !pin_wr |=>
        (pin_out_r & place($past(port_sel), '1))
        == place($past(port_sel), $past(port_wdata)))
        else $error("whole port write not applied");

    set_bits_a: assert property (disable iff (!rst_n)
        set_wr && !clr_wr && !pin_wr |=>
        (pin_out_r & place($past(setclr_sel), $past(setclr_mask)))
        == place($past(setclr_sel), $past(setclr_mask)))
        else $error("set write missed a pin");

    clr_keep_a: assert property (disable iff (!rst_n)
        clr_wr && !set_wr && !port_wr && !pin_wr |=>
        pin_out_r == ($past(pin_out_r)
                      & ~place($past(setclr_sel), $past(setclr_mask))))
        else $error("clear write disturbed other pins");

    pin_write_a: assert property (disable iff (!rst_n)
        pin_wr |=> pin_out_r[$past(pin_idx)] == $past(pin_wdata))
        else $error("pin write not applied");

    sync_delay_a: assert property (disable iff (!rst_n)
        ##2 lvl_r == $past(pin_in, 2))
        else $error("input synchroniser delay wrong");

    pin_read_a: assert property (disable iff (!rst_n)
        ##3 $past(pin_rd_idx) == $past(pin_rd_idx, 3) |->
        pin_rd_val_r == $past(pin_in[pin_rd_idx], 3))
        else $error("pin read not three cycles behind pin");

    grp_or_a: assert property (disable iff (!rst_n)
        !gand_r[0] && (gena_r[0] & ~(lvl_r ^ gpol_r[0])) != '0
        |=> grp_irq_r[0])
        else $error("group 0 missed a hit");

endmodule // gp_port

// ===== tb.sv
`timescale 1ns/1ps
`include "gp_params.svh"

module tb;
    logic        ref_clk     = 1'b0;
    logic        rst_b       = 1'b0;
    logic [63:0] ext_lvl     = 64'h0;
    logic [63:0] pin_in;
    logic [63:0] pin_out_r;
    logic [63:0] pin_oe_r;
    logic        dir_wr      = 1'b0;
    logic        dir_sel     = 1'b0;
    logic [31:0] dir_wdata   = 32'h0;
    logic        port_wr     = 1'b0;
    logic        port_sel    = 1'b0;
    logic [31:0] port_wdata  = 32'h0;
    logic        set_wr      = 1'b0;
    logic        clr_wr      = 1'b0;
    logic        setclr_sel  = 1'b0;
    logic [31:0] setclr_mask = 32'h0;
    logic        pin_wr      = 1'b0;
    logic [5:0]  pin_idx     = 6'h0;
    logic        pin_wdata   = 1'b0;
    logic [5:0]  pin_rd_idx  = 6'h0;
    logic        pin_rd_val_r;
    logic        port_rd_sel = 1'b0;
    logic [31:0] port_rd_val_r;
    logic        pint_wr     = 1'b0;
    logic [2:0]  pint_ch     = 3'h0;
    logic [5:0]  pint_src    = 6'h0;
    logic [2:0]  pint_mode   = 3'h0;
    logic [7:0]  pint_clr    = 8'h0;
    logic [7:0]  pint_req_r;
    logic        grp_wr      = 1'b0;
    logic        grp_id      = 1'b0;
    logic        grp_port    = 1'b0;
    logic [31:0] grp_ena     = 32'h0;
    logic [31:0] grp_pol     = 32'h0;
    logic        grp_and     = 1'b0;
    logic [1:0]  grp_irq_r;
    logic [31:0] seed        = 32'hecbf1d68;
    logic [63:0] dir_m       = 64'h0;
    logic [63:0] out_m       = 64'h0;
    logic [63:0] lvl;
    logic [31:0] hit;
    logic [2:0]  md;
    logic        want;
    int          n_fail      = 0;
    int          checked     = 0;
    int          cycles      = 0;

    always #12.5 ref_clk = ~ref_clk;

    gp_port gp_port_i (.ref_clk, .rst_b, .pin_in, .pin_out_r, .pin_oe_r,
        .dir_wr, .dir_sel, .dir_wdata, .port_wr, .port_sel, .port_wdata,
        .set_wr, .clr_wr, .setclr_sel, .setclr_mask, .pin_wr, .pin_idx,
        .pin_wdata, .pin_rd_idx, .pin_rd_val_r, .port_rd_sel,
        .port_rd_val_r, .pint_wr, .pint_ch, .pint_src, .pint_mode,
        .pint_clr, .pint_req_r, .grp_wr, .grp_id, .grp_port, .grp_ena,
        .grp_pol, .grp_and, .grp_irq_r);

    gp_ext_pins gp_ext_pins_i (.ext_lvl, .pin_out(pin_out_r),
        .pin_oe(pin_oe_r), .pin_in);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic complete_run();
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // Request expected per mode once the pin has settled at hi
    function automatic logic req_exp(input logic [2:0] m, input logic hi,
                                     input logic cleared);
        case (m)
            gp_pkg::GP_PM_HIGH: req_exp = hi;
            gp_pkg::GP_PM_LOW:  req_exp = !hi;
            gp_pkg::GP_PM_RISE: req_exp = hi && !cleared;
            gp_pkg::GP_PM_FALL: req_exp = !hi && !cleared;
            gp_pkg::GP_PM_BOTH: req_exp = !cleared;
            default:            req_exp = 1'b0;
        endcase
    endfunction

    // Group request from port levels, polarity and enables
    function automatic logic grp_exp(input logic and_m,
                                     input logic [31:0] lv,
                                     input logic [31:0] pol,
                                     input logic [31:0] ena);
        logic [31:0] hits;
        hits = ~(lv ^ pol) & ena;
        grp_exp = and_m ? (hits == ena && ena != 32'h0)
                        : (hits != 32'h0);
    endfunction

    task automatic rst_chk();
        chk(pin_oe_r, 64'h0);
        chk(pin_out_r, 64'h0);
        chk({pint_req_r, grp_irq_r}, 64'h0);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            complete_run();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        cyc(5);
        rst_chk();
        rst_b = 1'b1;
        cyc(3);
        for (int i = 0; i < 4; i++) begin
            dir_sel = i[0];
            dir_wdata = rnd();
            port_sel = i[0];
            port_wdata = rnd();
            dir_wr = 1'b1;
            port_wr = 1'b1;
            cyc(1);
            dir_m[32*i[0] +: 32] = dir_wdata;
            out_m[32*i[0] +: 32] = port_wdata;
            chk(pin_oe_r, dir_m);
            chk(pin_out_r, out_m);
        end
        dir_wr = 1'b0;
        port_wr = 1'b0;
        // Same-cycle set, clear and pin write: later one wins
        for (int i = 0; i < 12; i++) begin
            hit = rnd();
            setclr_sel = hit[0];
            set_wr = hit[1];
            clr_wr = hit[2];
            pin_wr = hit[3];
            pin_wdata = hit[4];
            pin_idx = hit[10:5];
            setclr_mask = rnd();
            cyc(1);
            if (hit[1]) out_m[32*hit[0] +: 32] |= setclr_mask;
            if (hit[2]) out_m[32*hit[0] +: 32] &= ~setclr_mask;
            if (hit[3]) out_m[hit[10:5]] = hit[4];
            chk(pin_out_r, out_m);
        end
        set_wr = 1'b0;
        clr_wr = 1'b0;
        pin_wr = 1'b0;
        for (int i = 0; i < 6; i++) begin
            ext_lvl = {rnd(), rnd()};
            hit = rnd();
            pin_rd_idx = hit[5:0];
            port_rd_sel = i[0];
            cyc(4);
            lvl = (dir_m & out_m) | (~dir_m & ext_lvl);
            chk(port_rd_val_r, lvl[32*i[0] +: 32]);
            chk(pin_rd_val_r, lvl[pin_rd_idx]);
        end
        ext_lvl = 64'h0;
        dir_wdata = 32'h0;
        dir_sel = 1'b0;
        dir_m = 64'h0;
        dir_wr = 1'b1;
        cyc(1);
        dir_sel = 1'b1;
        cyc(1);
        dir_wr = 1'b0;
        // Every mode code, one channel each, shared pins allowed
        for (int m = 0; m < 8; m++) begin
            md = m[2:0];
            pint_ch = md;
            hit = rnd();
            pint_src = hit[5:0];
            pint_mode = md;
            pint_wr = 1'b1;
            cyc(1);
            pint_wr = 1'b0;
            cyc(4);
            ext_lvl[pint_src] = 1'b1;
            cyc(5);
            chk(pint_req_r[md], req_exp(md, 1'b1, 1'b0));
            pint_clr[md] = 1'b1;
            cyc(1);
            pint_clr = 8'h0;
            cyc(3);
            chk(pint_req_r[md], req_exp(md, 1'b1, 1'b1));
            ext_lvl[pint_src] = 1'b0;
            cyc(5);
            chk(pint_req_r[md], req_exp(md, 1'b0, 1'b0));
        end
        for (int i = 0; i < 16; i++) begin
            hit = rnd();
            grp_id = hit[0];
            grp_and = hit[1];
            grp_port = ~hit[2];
            grp_ena = 32'h0;
            grp_wr = 1'b1;
            cyc(1);
            grp_port = hit[2];
            grp_ena = (i < 4) ? (32'h1 << hit[8:4]) : rnd();
            grp_pol = rnd();
            cyc(1);
            grp_wr = 1'b0;
            ext_lvl = {rnd(), rnd()};
            cyc(4);
            want = grp_exp(hit[1], ext_lvl[32*hit[2] +: 32], grp_pol,
                           grp_ena);
            chk(grp_irq_r[hit[0]], want);
        end
        rst_b = 1'b0;
        cyc(2);
        rst_chk();
        complete_run();
    end
endmodule // tb
